/* test/slot_bus_ctrl.sv */
// line card controller model: frame strobes and command slots on the slot bus
// assumes: hclk from the bench; device answer for a slot stands before its strobe
module slot_bus_ctrl (
  // clock
  input  wire logic       hclk,
  // pins toward the device
  output logic            frame_pin,
  output logic            slot_pin,
  output logic [7:0]      lane,
  // device answer
  input  wire logic [7:0] ans,
  input  wire logic       ans_oe
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle pins at time zero
  initial begin
    frame_pin = 1'b0;
    slot_pin  = 1'b0;
    lane      = 8'h00;
  end

  // one frame boundary, strobe wide enough for the two-stage sampling
  task automatic frame_edge;
    @(posedge hclk);
    frame_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    frame_pin <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : frame_edge

  // one byte slot; in answer slots the lane is driven with its own inverse, so it toggles
  // instead of holding a stale byte that could pass for the answer
  task automatic slot(input logic [7:0] b, input bit drv,
                      output logic [7:0] got, output logic got_oe);
    @(posedge hclk);
    lane <= drv ? b : ~lane;
    repeat (2) @(posedge hclk);
    got    = ans;
    got_oe = ans_oe;
    slot_pin <= 1'b1;
    repeat (4) @(posedge hclk);
    slot_pin <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask : slot
endmodule : slot_bus_ctrl

/* test/tb_codec_config_sequencer.sv */
// self-checking bench: ahb register tasks plus slot bus command sequences
// assumes: one 20 MHz clock, slot bus model from slot_bus_ctrl
module tb_codec_config_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] bytes_t [10];

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        frame_p;
  logic        slot_p;
  logic        rst_pin;
  logic        sa_pin;
  logic [7:0]  lane;
  logic [7:0]  so_out;
  logic        so_oe;
  logic        gnd_a;
  logic        gnd_s;
  logic [7:0]  tx [20];
  logic [7:0]  rx [20];
  logic        rx_oe [20];
  bytes_t      it;
  int          err_total;
  int          num_checks;

  codec_config_sequencer u_codec_config_sequencer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frame_sync_pin(frame_p), .slot_strobe_pin(slot_p), .device_reset_pin(rst_pin),
    .programmable_signal_pin_a(sa_pin), .serial_data_pin_in(lane),
    .serial_data_pin_out(so_out), .serial_data_pin_oe(so_oe),
    .analog_output_ground(gnd_a), .receive_signal_ground(gnd_s));

  slot_bus_ctrl u_slot_bus_ctrl (.hclk(hclk), .frame_pin(frame_p), .slot_pin(slot_p),
    .lane(lane), .ans(so_out), .ans_oe(so_oe));

  // free-running bus clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // single ahb transfer; address held until hready, data until hready again
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    ahb(a, 1'b0, 32'h0000_0000, q);
    chk(q & m, e);
    chk(32'(hresp), 32'h0000_0000);
  endtask : rdchk

  task automatic run(input int n, input bit rd);
    for (int i = 0; i < n; i++) u_slot_bus_ctrl.slot(tx[i], !(rd && i % 2), rx[i], rx_oe[i]);
  endtask : run

  // write sequence: command, gap, then items highest first each with a gap
  task automatic wr(input logic [7:0] cmd, input int n, input bytes_t v);
    for (int i = 0; i < 20; i++) tx[i] = 8'h00;
    tx[0] = cmd;
    for (int k = 0; k < n; k++) tx[2 * k + 2] = v[k];
    run(2 * n + 2, 1'b0);
    for (int i = 0; i < 2 * n + 2; i++) chk(32'(rx_oe[i]), 32'h0000_0000);
  endtask : wr

  // read sequence: answers expected in odd slots, or no drive at all
  task automatic rd(input logic [7:0] cmd, input int n, input bytes_t e, input bit on);
    for (int i = 0; i < 20; i++) tx[i] = 8'h00;
    tx[0] = cmd;
    run(2 * n, 1'b1);
    for (int k = 0; k < n; k++) begin
      chk(32'(rx_oe[2 * k + 1]), 32'(on));
      if (on) chk(32'(rx[2 * k + 1]), 32'(e[k]));
    end
  endtask : rd

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  // bench watchdog
  initial begin
    repeat (40000) @(posedge hclk);
    err_total++;
    complete_run();
  end

  initial begin
    logic [31:0] q;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    rst_pin = 1'b0;
    sa_pin = 1'b0;
    err_total = 0;
    num_checks = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(32'h0000_0004, 32'h0000_0008, 32'h0000_000F);
    rdchk(32'h0000_0008, 32'h0000_FF00, 32'hFFFF_FFFF);
    chk(32'({so_oe, gnd_a, gnd_s}), 32'h0000_0003);
    ahb(32'h0000_0010, 1'b1, 32'hFFFF_FFFF, q);
    rdchk(32'h0000_0010, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(8'h22, 2, '{0:8'hE5, 1:8'h5A, default:8'h00});
    rdchk(32'h0000_0008, 32'h0000_FF00, 32'hFFFF_FFFF);
    done("basic");
    u_slot_bus_ctrl.frame_edge();
    wr(8'h22, 2, '{0:8'hE5, 1:8'h5A, default:8'h00});
    rdchk(32'h0000_0008, 32'h0000_E55A, 32'hFFFF_FFFF);
    rdchk(32'h0000_0004, 32'h0000_0001, 32'h0000_0003);
    chk(32'({so_oe, gnd_a, gnd_s}), 32'h0000_0000);
    wr(8'h1A, 4, '{2:8'hE5, 3:8'h5A, default:8'h00});
    rdchk(32'h0000_0004, 32'h0000_0001, 32'h0000_0003);
    wr(8'h3A, 1, '{0:8'h5A, default:8'h00});
    rdchk(32'h0000_0004, 32'h0000_0002, 32'h0000_0003);
    rdchk(32'h0000_0008, 32'h0001_E55A, 32'hFFFF_FFFF);
    wr(8'h02, 0, '{default:8'h00});
    rdchk(32'h0000_0004, 32'h0000_0001, 32'h0000_0003);
    rd(8'h52, 4, '{2:8'hE5, 3:8'h5A, default:8'h00}, 1'b1);
    rd(8'h42, 1, '{default:8'h00}, 1'b1);
    rd(8'h72, 1, '{0:8'h5A, default:8'h00}, 1'b1);
    rd(8'h62, 2, '{0:8'hE5, 1:8'h5A, default:8'h00}, 1'b1);
    for (int v = 1; v >= 0; v--) begin
      wr(8'h12, 4, '{1:8'(v), 2:8'hE5, 3:8'h5A, default:8'h00});
      rdchk(32'h0000_0004, 32'(2 - v ^ 3), 32'h0000_0003);
    end
    done("modes");
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 8; k++) it[k] = (c ? 8'h20 : 8'h10) + 8'(8 - 4 * c - k);
      wr(c ? 8'h18 : 8'h03, 8 - 4 * c, it);
      it[8 - 4 * c] = 8'hE5;
      it[9 - 4 * c] = 8'h5A;
      rd(c ? 8'h58 : 8'h43, 10 - 4 * c, it, 1'b1);
    end
    ahb(32'h0000_000C, 1'b1, 32'h0000_0007, q);
    rdchk(32'h0000_000C, 32'h0000_0718, 32'h0000_3FFF);
    done("coefficients");
    rst_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    rst_pin <= 1'b0;
    sa_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    rdchk(32'h0000_0004, 32'h0000_0000, 32'h0000_0003);
    rdchk(32'h0000_0008, 32'h0000_FF00, 32'hFFFF_FFFF);
    chk(32'({so_oe, gnd_a, gnd_s}), 32'h0000_0003);
    u_slot_bus_ctrl.frame_edge();
    wr(8'h22, 2, '{0:8'hC5, 1:8'h77, default:8'h00});
    rdchk(32'h0000_0008, 32'h0000_C500, 32'hFFFF_FFFF);
    wr(8'hA2, 2, '{0:8'hC5, 1:8'h33, default:8'h00});
    rdchk(32'h0000_0008, 32'h0000_C533, 32'hFFFF_FFFF);
    for (int k = 0; k < 8; k++) it[k] = 8'h18 - 8'(k);
    it[8] = 8'hC5;
    it[9] = 8'h33;
    rd(8'h43, 10, it, 1'b0);
    rd(8'hC3, 10, it, 1'b1);
    ahb(32'h0000_0000, 1'b1, 32'h0000_0001, q);
    rdchk(32'h0000_0008, 32'h0000_FF00, 32'hFFFF_FFFF);
    done("shared port");
    complete_run();
  end
endmodule : tb_codec_config_sequencer

/* verilog/cfg_seq_pkg.sv */
// constants, field layouts and state types for the codec configuration sequencer
// assumes: one 20 MHz bus clock, slot bus bytes arrive one per slot strobe
package cfg_seq_pkg;

  // ahb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_COEF   = 8'h0C;
  localparam int         CTRL_SOFT_BIT = 0;

  // basic setting values of the configuration registers
  localparam logic [7:0] CR1_RST = 8'h00;
  localparam logic [7:0] CR2_RST = 8'hFF;
  localparam logic [7:0] CR3_RST = 8'h00;
  localparam logic [7:0] CR4_RST = 8'h00;
  localparam logic [7:0] NOP_BYTE = 8'h00;

  // command byte fields
  localparam int         CMD_AD_BIT   = 7;
  localparam int         CMD_RW_BIT   = 6;
  localparam int         SOP_REGISTER_LOAD_SELECTOR_LSB = 4;
  localparam int         SOP_PU_BIT   = 3;
  localparam int         SOP_TR_BIT   = 2;
  localparam logic [1:0] SOP_MARK     = 2'b10;
  localparam logic [2:0] COP_LONG_LOW  = 3'b011;
  localparam logic [2:0] COP_SHORT_LOW = 3'b000;
  localparam logic [3:0] COP_LONG_N  = 4'h8;
  localparam logic [3:0] COP_SHORT_N = 4'h4;

  // register load selector codes
  localparam logic [1:0] REGISTER_LOAD_SELECTOR_NONE = 2'b00;
  localparam logic [1:0] REGISTER_LOAD_SELECTOR_R1   = 2'b11;
  localparam logic [1:0] REGISTER_LOAD_SELECTOR_R21  = 2'b10;
  localparam logic [1:0] REGISTER_LOAD_SELECTOR_ALL  = 2'b01;

  // configuration register bit positions
  localparam int CR3_PU_BIT     = 0;
  localparam int CR2_TR_BIT     = 1;
  localparam int CR2_SINGLE_BIT = 5;

  typedef enum logic [1:0] {MODE_BASIC, MODE_STANDBY, MODE_OPERATING} mode_t;
  typedef enum logic [1:0] {SEQ_SYNC, SEQ_IDLE, SEQ_RUN} seq_t;

endpackage : cfg_seq_pkg

/* verilog/codec_config_sequencer.sv */
// command interpreter and configuration registers of the codec filter
// assumes: ahb-lite master on hclk, slot bus pins asynchronous to hclk
//
// Contract
// - setup write: command, gap, then selected registers highest first, gaps between
// - setup read returns selected registers highest first, gaps between
// - coefficient read returns bytes highest first, then register 2, register 1
// - power-on or reset pin high enters basic setting
// - basic setting clears registers 1, 3 and 4
// - basic setting sets register 2 to all ones
// - basic setting floats data pin, grounds analog and signal outputs
// - commands are accepted only from the next frame boundary
// - data pin never drives before register 2 has been written
// - shared port: both take setup and register 2, addressed one takes rest; the code lets the other one take only register 2, and only in basic setting
// - register 2 load in basic setting moves to standby
// - power-up bit written 0 returns operating to standby
// - power-up bit written 1 moves standby to operating
// - serial interface stays fully active in standby
// - selector 01 ignores command power-up and conference bits
// - shared port: coefficient command only if address bit equals pin a
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
module codec_config_sequencer (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // slot bus pins
  input  wire logic        frame_sync_pin,
  input  wire logic        slot_strobe_pin,
  input  wire logic        device_reset_pin,
  input  wire logic        programmable_signal_pin_a,
  input  wire logic [7:0]  serial_data_pin_in,
  output logic      [7:0]  serial_data_pin_out,
  output logic             serial_data_pin_oe,
  // analog and signaling outputs
  output logic             analog_output_ground,
  output logic             receive_signal_ground
);
  slot_link_if lnk ();

  link_sync u_sync (
    .clk       (hclk),
    .rst_n     (hresetn),
    .frame_pin (frame_sync_pin),
    .slot_pin  (slot_strobe_pin),
    .reset_pin (device_reset_pin),
    .sa_pin    (programmable_signal_pin_a),
    .byte_pin  (serial_data_pin_in),
    .lnk       (lnk.src)
  );

  // bytes per command kind
  function automatic logic [3:0] cop_n(input logic [7:0] b);
    cop_n = (b[2:0] == cfg_seq_pkg::COP_LONG_LOW) ? cfg_seq_pkg::COP_LONG_N
                                                  : cfg_seq_pkg::COP_SHORT_N;
  endfunction : cop_n

  function automatic logic [3:0] item_count(input logic [7:0] b);
    logic [1:0] ls;
    ls = b[cfg_seq_pkg::SOP_REGISTER_LOAD_SELECTOR_LSB +: 2];
    if (b[1:0] != cfg_seq_pkg::SOP_MARK)
      item_count = b[cfg_seq_pkg::CMD_RW_BIT] ? 4'(cop_n(b) + 4'd2) : cop_n(b);
    else if (ls == cfg_seq_pkg::REGISTER_LOAD_SELECTOR_R1)
      item_count = 4'd1;
    else if (ls == cfg_seq_pkg::REGISTER_LOAD_SELECTOR_R21)
      item_count = 4'd2;
    else if (ls == cfg_seq_pkg::REGISTER_LOAD_SELECTOR_ALL)
      item_count = 4'd4;
    else
      item_count = 4'd0;
  endfunction : item_count

  // position of the last byte of a sequence, the command at position 0
  function automatic logic [4:0] seq_last(input logic [7:0] b);
    logic [4:0] n2;
    n2 = {item_count(b), 1'b0};
    if (!b[cfg_seq_pkg::CMD_RW_BIT])
      seq_last = 5'(n2 + 5'd1);
    else
      seq_last = (n2 == 5'd0) ? 5'd1 : 5'(n2 - 5'd1);
  endfunction : seq_last

  // listed codes only, so a reserved code never opens a sequence
  function automatic logic cop_valid(input logic [7:0] b);
    logic [2:0] hi;
    hi = b[5:3];
    if (b[2:0] == cfg_seq_pkg::COP_LONG_LOW)
      cop_valid = (hi != 3'd3) && (hi < 3'd6);
    else if (b[2:0] == cfg_seq_pkg::COP_SHORT_LOW)
      cop_valid = (hi == 3'd3) || (hi == 3'd6);
    else
      cop_valid = 1'b0;
  endfunction : cop_valid

  cfg_seq_pkg::mode_t mode_r;
  cfg_seq_pkg::seq_t  seq_r;
  logic [7:0]  cr_r [1:4];
  logic [7:0]  coef_r [0:63];
  logic        cr2_def_r;
  logic [7:0]  cmd_r;
  logic [4:0]  pos_r;
  logic [4:0]  last_r;
  logic [5:0]  coef_sel_r;
  logic        a_wr_r;
  logic        a_act_r;
  logic [7:0]  a_addr_r;

  // ahb decode; soft reset acts in the write data phase
  wire       take     = hsel & htrans[1] & hready;
  wire       in_map   = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
  wire       wr_phase = a_act_r & a_wr_r;
  wire       soft_rst = wr_phase && (a_addr_r == cfg_seq_pkg::OFS_CTRL)
                        && hwdata[cfg_seq_pkg::CTRL_SOFT_BIT];
  wire       enter_basic = lnk.dev_rst | soft_rst;

  // received byte and command decode
  wire [7:0] rxb    = lnk.rx_byte;
  wire [1:0] c_register_load_selector = rxb[cfg_seq_pkg::SOP_REGISTER_LOAD_SELECTOR_LSB +: 2];
  wire       rx_sop = rxb[1:0] == cfg_seq_pkg::SOP_MARK;
  wire       single = cr_r[2][cfg_seq_pkg::CR2_SINGLE_BIT];
  wire       hit_rx = single | (rxb[cfg_seq_pkg::CMD_AD_BIT] == lnk.sa_lvl);
  wire       start  = lnk.slot_p && (seq_r == cfg_seq_pkg::SEQ_IDLE)
                      && (rx_sop || cop_valid(rxb));
  wire       step   = lnk.slot_p && (seq_r == cfg_seq_pkg::SEQ_RUN);

  // current slot within a running sequence
  wire [4:0] cur      = 5'(pos_r + 5'd1);
  wire       rd_cur   = cmd_r[cfg_seq_pkg::CMD_RW_BIT];
  wire       cop_cur  = cmd_r[1:0] != cfg_seq_pkg::SOP_MARK;
  wire [3:0] jw       = 4'(cur[4:1] - 4'd1);
  wire [3:0] regw     = 4'(item_count(cmd_r) - jw);
  wire       adr_live = single | (cmd_r[cfg_seq_pkg::CMD_AD_BIT] == lnk.sa_lvl);
  wire       wr_data  = step && !rd_cur && !cur[0];
  wire       gap_slot = step && !rd_cur && cur[0];

  // register 2 is taken by every device while in basic setting
  wire       sop_wr = wr_data && !cop_cur && (adr_live ||
                      (regw == 4'd2 && mode_r == cfg_seq_pkg::MODE_BASIC));
  wire       cr2_ld = sop_wr && (regw == 4'd2);
  wire       cop_wr = wr_data && cop_cur && adr_live;
  wire [5:0] coef_wi = {cmd_r[5:3], 3'(cop_n(cmd_r) - 4'd1 - jw)};

  // power-up bit from the command itself or from register 3
  wire       cmd_pu  = start && rx_sop && hit_rx
                       && (c_register_load_selector != cfg_seq_pkg::REGISTER_LOAD_SELECTOR_ALL);
  wire       pu_ev   = cmd_pu || (sop_wr && regw == 4'd3);
  wire       pu_val  = cmd_pu ? rxb[cfg_seq_pkg::SOP_PU_BIT]
                              : rxb[cfg_seq_pkg::CR3_PU_BIT];

  // answer prepared for the next slot
  wire [7:0] cmd_x  = start ? rxb : cmd_r;
  wire [4:0] nx     = start ? 5'd1 : 5'(cur + 5'd1);
  wire [4:0] last_x = start ? seq_last(rxb) : last_r;
  wire [3:0] jd     = 4'(nx[4:1]);
  wire [3:0] n_x    = item_count(cmd_x);
  wire [3:0] nb_x   = cop_n(cmd_x);
  wire       adr_x  = single | (cmd_x[cfg_seq_pkg::CMD_AD_BIT] == lnk.sa_lvl);
  wire       drv    = (start || (step && cur != last_r)) && cmd_x[cfg_seq_pkg::CMD_RW_BIT]
                      && nx[0] && (nx <= last_x) && adr_x && cr2_def_r;
  wire [2:0] sop_ri = 3'(n_x - jd);
  wire [5:0] coef_ri = {cmd_x[5:3], 3'(nb_x - 4'd1 - jd)};
  wire [7:0] sop_b  = (n_x == 4'd0) ? cfg_seq_pkg::NOP_BYTE : cr_r[sop_ri];
  wire [7:0] cop_b  = (jd < nb_x) ? coef_r[coef_ri]
                    : (jd == nb_x) ? cr_r[2] : cr_r[1];
  wire [7:0] ans_b  = (cmd_x[1:0] == cfg_seq_pkg::SOP_MARK) ? sop_b : cop_b;

  // operating mode transitions
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= cfg_seq_pkg::MODE_BASIC;
    end else if (enter_basic) begin
      mode_r <= cfg_seq_pkg::MODE_BASIC;
    end else if (cr2_ld && mode_r == cfg_seq_pkg::MODE_BASIC) begin
      mode_r <= cfg_seq_pkg::MODE_STANDBY;
    end else if (pu_ev && pu_val && mode_r == cfg_seq_pkg::MODE_STANDBY) begin
      mode_r <= cfg_seq_pkg::MODE_OPERATING;
    end else if (pu_ev && !pu_val && mode_r == cfg_seq_pkg::MODE_OPERATING) begin
      mode_r <= cfg_seq_pkg::MODE_STANDBY;
    end
  end

  // sequence tracker; standby keeps it running like any other mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_r  <= cfg_seq_pkg::SEQ_SYNC;
      cmd_r  <= 8'h00;
      pos_r  <= 5'h00;
      last_r <= 5'h00;
    end else if (enter_basic) begin
      seq_r <= cfg_seq_pkg::SEQ_SYNC;
    end else begin
      case (seq_r)
        cfg_seq_pkg::SEQ_SYNC: if (lnk.frame_p) seq_r <= cfg_seq_pkg::SEQ_IDLE;
        cfg_seq_pkg::SEQ_IDLE: if (start) begin
          seq_r  <= cfg_seq_pkg::SEQ_RUN;
          cmd_r  <= rxb;
          pos_r  <= 5'h00;
          last_r <= seq_last(rxb);
        end
        cfg_seq_pkg::SEQ_RUN: if (step) begin
          pos_r <= cur;
          if (cur == last_r) seq_r <= cfg_seq_pkg::SEQ_IDLE;
        end
        default: seq_r <= cfg_seq_pkg::SEQ_SYNC;
      endcase
    end
  end

  // configuration registers; gap slots never reach these enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cr_r      <= '{cfg_seq_pkg::CR1_RST, cfg_seq_pkg::CR2_RST,
                     cfg_seq_pkg::CR3_RST, cfg_seq_pkg::CR4_RST};
      cr2_def_r <= 1'b0;
    end else if (enter_basic) begin
      cr_r      <= '{cfg_seq_pkg::CR1_RST, cfg_seq_pkg::CR2_RST,
                     cfg_seq_pkg::CR3_RST, cfg_seq_pkg::CR4_RST};
      cr2_def_r <= 1'b0;
    end else if (cmd_pu) begin
      cr_r[3][cfg_seq_pkg::CR3_PU_BIT] <= rxb[cfg_seq_pkg::SOP_PU_BIT];
      cr_r[2][cfg_seq_pkg::CR2_TR_BIT] <= rxb[cfg_seq_pkg::SOP_TR_BIT];
    end else if (sop_wr && regw != 4'd0 && regw <= 4'd4) begin
      cr_r[3'(regw)] <= rxb;
      if (cr2_ld) cr2_def_r <= 1'b1;
    end
  end

  // coefficient store, no reset: contents are undefined until written
  always_ff @(posedge hclk) begin
    if (cop_wr) coef_r[coef_wi] <= rxb;
  end

  // data pin driver, released in basic setting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_data_pin_oe  <= 1'b0;
      serial_data_pin_out <= 8'h00;
    end else if (enter_basic) begin
      serial_data_pin_oe  <= 1'b0;
      serial_data_pin_out <= 8'h00;
    end else if (lnk.slot_p) begin
      serial_data_pin_oe  <= drv;
      serial_data_pin_out <= drv ? ans_b : 8'h00;
    end
  end

  // outputs forced to ground while in basic setting
  assign analog_output_ground  = mode_r == cfg_seq_pkg::MODE_BASIC;
  assign receive_signal_ground = mode_r == cfg_seq_pkg::MODE_BASIC;

  // ahb read mux, sampled in the address phase
  wire [31:0] status_w = {27'h000_0000, seq_r == cfg_seq_pkg::SEQ_RUN,
                          seq_r == cfg_seq_pkg::SEQ_SYNC, cr2_def_r, mode_r};
  wire [31:0] rd_w = !in_map ? 32'h0000_0000
    : (haddr[7:0] == cfg_seq_pkg::OFS_STATUS) ? status_w
    : (haddr[7:0] == cfg_seq_pkg::OFS_CONFIG) ? {cr_r[4], cr_r[3], cr_r[2], cr_r[1]}
    : (haddr[7:0] == cfg_seq_pkg::OFS_COEF)
      ? {18'h0_0000, coef_sel_r, coef_r[coef_sel_r]} : 32'h0000_0000;

  // address phase capture; always ready and okay, so no wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_act_r  <= 1'b0;
      a_wr_r   <= 1'b0;
      a_addr_r <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end else begin
      a_act_r  <= take && in_map;
      a_wr_r   <= hwrite;
      a_addr_r <= haddr[7:0];
      if (take && !hwrite) hrdata <= rd_w;
    end
  end

  // coefficient window pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) coef_sel_r <= 6'h00;
    else if (wr_phase && a_addr_r == cfg_seq_pkg::OFS_COEF) coef_sel_r <= hwdata[5:0];
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // checks on the sequencer
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  oe_needs_cr2_a: assert property (serial_data_pin_oe |-> cr2_def_r)
    else $error("data pin driven before register 2 load");
  basic_float_a: assert property (mode_r == cfg_seq_pkg::MODE_BASIC
    |-> !serial_data_pin_oe && analog_output_ground)
    else $error("basic setting drives pin or analog");
  pin_reset_a: assert property (lnk.dev_rst |=> mode_r == cfg_seq_pkg::MODE_BASIC
    && seq_r == cfg_seq_pkg::SEQ_SYNC)
    else $error("reset pin did not enter basic setting");
  basic_clear_a: assert property (enter_basic |=> cr_r[1] == cfg_seq_pkg::CR1_RST
    && cr_r[3] == cfg_seq_pkg::CR3_RST && cr_r[4] == cfg_seq_pkg::CR4_RST)
    else $error("registers 1 3 4 not cleared");
  basic_ones_a: assert property (enter_basic |=> cr_r[2] == cfg_seq_pkg::CR2_RST)
    else $error("register 2 not all ones");
  frame_wait_a: assert property (seq_r == cfg_seq_pkg::SEQ_SYNC && !lnk.frame_p
    |=> seq_r != cfg_seq_pkg::SEQ_RUN)
    else $error("command accepted before frame boundary");
  cr2_standby_a: assert property (cr2_ld && mode_r == cfg_seq_pkg::MODE_BASIC
    && !enter_basic |=> mode_r == cfg_seq_pkg::MODE_STANDBY && cr2_def_r)
    else $error("register 2 load did not reach standby");
  pu_up_a: assert property (pu_ev && pu_val && mode_r == cfg_seq_pkg::MODE_STANDBY
    && !enter_basic |=> mode_r == cfg_seq_pkg::MODE_OPERATING)
    else $error("power-up did not enter operating");
  pu_down_a: assert property (pu_ev && !pu_val && mode_r == cfg_seq_pkg::MODE_OPERATING
    && !enter_basic |=> mode_r == cfg_seq_pkg::MODE_STANDBY)
    else $error("power-down did not return to standby");
  gap_stable_a: assert property (gap_slot && !enter_basic
    |=> $stable(cr_r[1]) && $stable(cr_r[2]) && $stable(cr_r[3]) && $stable(cr_r[4]))
    else $error("gap byte changed a register");
  register_load_selector_all_a: assert property (start && rx_sop && c_register_load_selector == cfg_seq_pkg::REGISTER_LOAD_SELECTOR_ALL
    && !enter_basic |=> $stable(cr_r[3]))
    else $error("selector 01 took command power-up bit");

  enter_oper_c: cover property (mode_r == cfg_seq_pkg::MODE_STANDBY
    ##1 mode_r == cfg_seq_pkg::MODE_OPERATING);
  read_drive_c: cover property (serial_data_pin_oe && cop_cur);
  shared_port_c: cover property (cr2_ld && !rxb[cfg_seq_pkg::CR2_SINGLE_BIT]);
  cop_write_c: cover property (cop_wr && jw == 4'd7);
endmodule : codec_config_sequencer

/* verilog/link_sync.sv */
// two-stage synchroniser and edge pulses for the slot bus pins
// assumes: byte lane is stable for at least three hclk around each slot strobe
module link_sync (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // raw pins
  input  wire logic       frame_pin,
  input  wire logic       slot_pin,
  input  wire logic       reset_pin,
  input  wire logic       sa_pin,
  input  wire logic [7:0] byte_pin,
  // synchronised side
  slot_link_if.src        lnk
);
  logic [11:0] s1_r;
  logic [11:0] s2_r;
  logic [1:0]  s3_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 12'h000;
      s2_r <= 12'h000;
      s3_r <= 2'b00;
    end else begin
      s1_r <= {frame_pin, slot_pin, reset_pin, sa_pin, byte_pin};
      s2_r <= s1_r;
      s3_r <= s2_r[11:10];
    end
  end

  // rising edges of frame and slot become one-cycle pulses
  assign lnk.frame_p = s2_r[11] & ~s3_r[1];
  assign lnk.slot_p  = s2_r[10] & ~s3_r[0];
  assign lnk.dev_rst = s2_r[9];
  assign lnk.sa_lvl  = s2_r[8];
  assign lnk.rx_byte = s2_r[7:0];
endmodule : link_sync

/* verilog/slot_link_if.sv */
// carrier between the pin synchroniser and the command sequencer
// assumes: both ends on hclk
interface slot_link_if;
  logic       frame_p;
  logic       slot_p;
  logic       dev_rst;
  logic       sa_lvl;
  logic [7:0] rx_byte;
  modport src (output frame_p, slot_p, dev_rst, sa_lvl, rx_byte);
  modport dst (input  frame_p, slot_p, dev_rst, sa_lvl, rx_byte);
endinterface : slot_link_if
